// [hdl/tpc_config_bank.sv]
// provisioning and reporting settings of the transport functions
// assumes a management side issuing one command per cycle, one clock
`timescale 1ns/100ps
`default_nettype none
`include "tpc_params.svh"

// Function
// - each adaptation function has its own activation bit, reset false.
// - single function, single client: activation fixed, writes refused.
// - on request, latch and return the accepted payload label.
// - AUG structure always holds AUG1; every group defined to AU level.
// - AU-4 and AU-4-16c only: AUG16 picks 1xAU-4-16c or 16xAU-4.
// - with AU-4-4c: AUG16 picks 4xAUG4, each AUG4 picks AU-4-4c or 4xAU-4.
// - pass-through node: protection AUG structure follows incoming one.
// - report the AUG structure detected in the received signal.
// - TUG structure has three TUG3s, optional TUG2s, defined to TU level.
// - TU3 and TU12 only: each TUG3 picks 1xTU3 or 21xTU12.
// - with TU2: TUG3 picks 7xTUG2, each TUG2 picks TU2 or 3xTU12.
// - a management write replaces the default multiplex structure.
// - connection has point ids, kind and direction, none defaulted.
// - working and normal share an id; extra traffic reuses protection id.
// - degraded threshold defaults to SES estimator; period defaults to 7.
// - port mode monitored, auto or not monitored; auto default if supported.
// - termination point mode monitored or not, default not monitored.
module tpc_config_bank
  import tpc_pkg::*;
#(
  parameter int        NUM_AF        = 1,
  parameter bit        SINGLE_CLIENT = 1'b1,
  parameter bit        FIXED_ACTIVE  = 1'b1,
  parameter bit        SUP_AU4_16C   = 1'b1,
  parameter bit        SUP_AU4_4C    = 1'b1,
  parameter bit        SUP_TU3       = 1'b1,
  parameter bit        SUP_TU2       = 1'b1,
  parameter bit        SUP_PORT_AUTO = 1'b1,
  parameter tpc_aug_t  AUG_DEFAULT   = '0,
  parameter tpc_tug_t  TUG_DEFAULT   = '1
) (
  // clock and reset
  input  wire  logic                          core_clk,
  input  wire  logic                          sys_rst,
  // management command
  input  wire  logic                          cmd_valid,
  input  wire  tpc_item_t                     cmd_item,
  input  wire  logic [`TPC_CMD_IDX_W-1:0]     cmd_index,
  input  wire  logic [`TPC_CMD_DATA_W-1:0]    cmd_data,
  output var   logic                          cmd_accept,
  output var   logic                          cmd_reject,
  // payload label report
  input  wire  logic                          label_req,
  input  wire  logic [`TPC_LABEL_W-1:0]       rx_payload_label,
  output var   logic [`TPC_LABEL_W-1:0]       accepted_payload_label,
  output var   logic                          label_valid,
  // received and ring structure
  input  wire  logic                          ring_pass_through,
  input  wire  logic                          rx_aug_valid,
  input  wire  tpc_aug_t                      rx_aug_detect,
  output var   tpc_aug_t                      rx_aug_report,
  // provisioned settings
  output var   logic [`TPC_AF_MAX-1:0]        client_activate,
  output var   tpc_aug_t                      aug_work_cfg,
  output var   tpc_aug_t                      aug_prot_cfg,
  output var   tpc_tug_t                      tug_cfg,
  output var   tpc_conn_t                     conn_cfg,
  output var   logic [`TPC_AP_ID_W-1:0]       ap_working_id,
  output var   logic [`TPC_AP_ID_W-1:0]       ap_normal_id,
  output var   logic [`TPC_AP_ID_W-1:0]       ap_protection_id,
  output var   logic [`TPC_AP_ID_W-1:0]       ap_extra_id,
  output var   logic                          degraded_use_ses,
  output var   logic [`TPC_DEG_THR_W-1:0]     degraded_block_threshold,
  output var   logic [`TPC_DEG_M_W-1:0]       degraded_period_count,
  output var   tpc_port_mode_t                port_monitor_setting,
  output var   tpc_tp_mode_t                  termination_monitor_setting
);

  localparam bit ACT_FIXED = (NUM_AF == 1) && SINGLE_CLIENT && FIXED_ACTIVE;
  localparam logic [`TPC_AF_MAX-1:0] ACT_RST =
    ACT_FIXED ? {{(`TPC_AF_MAX-1){1'b0}}, 1'b1}
              : {`TPC_AF_MAX{`TPC_ACTIVE_RST}};

  // elaboration checks
  if (NUM_AF < 1 || NUM_AF > `TPC_AF_MAX) begin : g_bad_af
    $error("NUM_AF out of range");
  end
  if (!SUP_AU4_16C && AUG_DEFAULT.aug16_split == 1'b0) begin : g_bad_aug
    $error("AUG default not supported");
  end
  if (!SUP_AU4_4C && AUG_DEFAULT.aug4_split != '1) begin : g_bad_aug4
    $error("AUG4 default needs AU-4-4c support");
  end
  if (!SUP_TU3 && TUG_DEFAULT.tug3_split != '1) begin : g_bad_tug3
    $error("TUG3 default needs TU3 support");
  end
  if (!SUP_TU2 && TUG_DEFAULT.tug2_split != '1) begin : g_bad_tug
    $error("TUG2 default needs TU2 support");
  end

  localparam tpc_state_t RST_ST = '{
    active:      ACT_RST,
    label:       '0,
    label_valid: 1'b0,
    aug_work:    AUG_DEFAULT,
    aug_prot:    AUG_DEFAULT,
    aug_rx:      '0,
    tug:         TUG_DEFAULT,
    conn:        '0,
    ap_work_id:  '0,
    ap_prot_id:  '0,
    deg_ses:     `TPC_DEG_SES_RST,
    deg_thr:     `TPC_DEG_THR_RST,
    deg_m:       `TPC_DEG_M_RST,
    port_mode:   SUP_PORT_AUTO ? TPC_PORT_AUTO : TPC_PORT_NOT_MONITORED,
    tp_mode:     TPC_TP_NOT_MONITORED,
    accept:      1'b0,
    reject:      1'b0
  };

  tpc_state_t st_r;
  tpc_state_t st_nxt;

  logic                    ok;
  logic                    bit0;
  logic [`TPC_DEG_M_W-1:0] m_val;
  tpc_port_mode_t          pm_val;

  assign bit0   = cmd_data[0];
  assign m_val  = cmd_data[`TPC_DEG_M_W-1:0];
  assign pm_val = tpc_port_mode_t'(cmd_data[1:0]);

  always_comb begin
    st_nxt        = st_r;
    ok            = 1'b0;
    st_nxt.accept = 1'b0;
    st_nxt.reject = 1'b0;

    // label snapshot on request
    st_nxt.label_valid = label_req;
    if (label_req) begin
      st_nxt.label = rx_payload_label;
    end

    // received structure for fault localisation
    if (rx_aug_valid) begin
      st_nxt.aug_rx = rx_aug_detect;
    end

    if (cmd_valid) begin
      unique case (cmd_item)
        TPC_ITEM_ACTIVE: begin
          ok = !ACT_FIXED && (int'(cmd_index) < NUM_AF);
          if (ok) begin
            st_nxt.active[cmd_index[2:0]] = bit0;
          end
        end
        TPC_ITEM_AUG16: begin
          // unsplit means 1xAU-4-16c
          ok = bit0 || SUP_AU4_16C;
          if (ok) begin
            st_nxt.aug_work.aug16_split = bit0;
          end
        end
        TPC_ITEM_AUG4: begin
          // no AUG4 level without AU-4-4c
          ok = SUP_AU4_4C && (int'(cmd_index) < `TPC_AUG4_NUM);
          if (ok) begin
            st_nxt.aug_work.aug4_split[cmd_index[1:0]] = bit0;
          end
        end
        TPC_ITEM_TUG3: begin
          ok = (int'(cmd_index) < `TPC_TUG3_NUM) &&
               (bit0 || SUP_TU3);
          if (ok) begin
            st_nxt.tug.tug3_split[cmd_index[1:0]] = bit0;
          end
        end
        TPC_ITEM_TUG2: begin
          // index counts TUG2s across all three TUG3s
          ok = SUP_TU2 && (int'(cmd_index) < `TPC_TUG2_NUM);
          if (ok) begin
            st_nxt.tug.tug2_split[cmd_index] = bit0;
          end
        end
        TPC_ITEM_CONN: begin
          ok = 1'b1;
          st_nxt.conn.cp_ids  = cmd_data[`TPC_CP_NUM*`TPC_CP_ID_W-1:0];
          st_nxt.conn.kind    =
            tpc_conn_kind_t'(cmd_data[`TPC_CONN_KIND_BIT]);
          st_nxt.conn.dir     =
            tpc_conn_dir_t'(cmd_data[`TPC_CONN_DIR_BIT]);
          st_nxt.conn.defined = 1'b1;
        end
        TPC_ITEM_AP_WORK: begin
          ok = 1'b1;
          st_nxt.ap_work_id = cmd_data[`TPC_AP_ID_W-1:0];
        end
        TPC_ITEM_AP_PROT: begin
          ok = 1'b1;
          st_nxt.ap_prot_id = cmd_data[`TPC_AP_ID_W-1:0];
        end
        TPC_ITEM_DEG_THR: begin
          ok = 1'b1;
          st_nxt.deg_ses = cmd_data[`TPC_DEG_SES_BIT];
          st_nxt.deg_thr = cmd_data[`TPC_DEG_THR_W-1:0];
        end
        TPC_ITEM_DEG_M: begin
          ok = (m_val >= `TPC_DEG_M_MIN) && (m_val <= `TPC_DEG_M_MAX);
          if (ok) begin
            st_nxt.deg_m = m_val;
          end
        end
        TPC_ITEM_PORT_MODE: begin
          ok = (pm_val == TPC_PORT_MONITORED) ||
               (pm_val == TPC_PORT_NOT_MONITORED) ||
               ((pm_val == TPC_PORT_AUTO) && SUP_PORT_AUTO);
          if (ok) begin
            st_nxt.port_mode = pm_val;
          end
        end
        TPC_ITEM_TP_MODE: begin
          ok = 1'b1;
          st_nxt.tp_mode = tpc_tp_mode_t'(bit0);
        end
        default: begin
          ok = 1'b0;
        end
      endcase
      st_nxt.accept = ok;
      st_nxt.reject = !ok;
    end

    // protection bandwidth tracks incoming structure in pass-through
    if (ring_pass_through) begin
      if (rx_aug_valid) begin
        st_nxt.aug_prot = rx_aug_detect;
      end
    end else begin
      st_nxt.aug_prot = st_nxt.aug_work;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign cmd_accept                  = st_r.accept;
  assign cmd_reject                  = st_r.reject;
  assign accepted_payload_label      = st_r.label;
  assign label_valid                 = st_r.label_valid;
  assign rx_aug_report               = st_r.aug_rx;
  assign client_activate             = st_r.active;
  assign aug_work_cfg                = st_r.aug_work;
  assign aug_prot_cfg                = st_r.aug_prot;
  assign tug_cfg                     = st_r.tug;
  assign conn_cfg                    = st_r.conn;
  assign ap_working_id               = st_r.ap_work_id;
  assign ap_normal_id                = st_r.ap_work_id;
  assign ap_protection_id            = st_r.ap_prot_id;
  assign ap_extra_id                 = st_r.ap_prot_id;
  assign degraded_use_ses            = st_r.deg_ses;
  assign degraded_block_threshold    = st_r.deg_thr;
  assign degraded_period_count       = st_r.deg_m;
  assign port_monitor_setting        = st_r.port_mode;
  assign termination_monitor_setting = st_r.tp_mode;

endmodule

`default_nettype wire

// [hdl/tpc_params.svh]
// reset values, ranges and sizes of the transport provisioning settings
// assumes inclusion by tpc_pkg, the register bank and the port checker only
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// sizes of the packed state and of the command fields
`define TPC_AF_MAX        8
`define TPC_LABEL_W       8
`define TPC_CP_NUM        2
`define TPC_CP_ID_W       12
`define TPC_AP_ID_W       12
`define TPC_DEG_THR_W     16
`define TPC_DEG_M_W       4
`define TPC_CMD_DATA_W    32
`define TPC_CMD_IDX_W     5

// multiplex structure extents
`define TPC_AUG4_NUM      4
`define TPC_TUG3_NUM      3
`define TPC_TUG2_PER_TUG3 7
`define TPC_TUG2_NUM      21

// reset values and period range
`define TPC_ACTIVE_RST    1'b0
`define TPC_DEG_THR_RST   16'h0000
`define TPC_DEG_SES_RST   1'b1
`define TPC_DEG_M_RST     4'h7
`define TPC_DEG_M_MIN     4'h2
`define TPC_DEG_M_MAX     4'hA

// command data field positions
`define TPC_CONN_KIND_BIT 24
`define TPC_CONN_DIR_BIT  25
`define TPC_DEG_SES_BIT   16

`endif

// [hdl/tpc_pkg.sv]
// types of the transport provisioning register bank
// assumes tpc_params.svh on the include path
`include "tpc_params.svh"

package tpc_pkg;

  typedef enum logic [3:0] {
    TPC_ITEM_ACTIVE    = 4'h0,
    TPC_ITEM_AUG16     = 4'h1,
    TPC_ITEM_AUG4      = 4'h2,
    TPC_ITEM_TUG3      = 4'h3,
    TPC_ITEM_TUG2      = 4'h4,
    TPC_ITEM_CONN      = 4'h5,
    TPC_ITEM_AP_WORK   = 4'h6,
    TPC_ITEM_AP_PROT   = 4'h7,
    TPC_ITEM_DEG_THR   = 4'h8,
    TPC_ITEM_DEG_M     = 4'h9,
    TPC_ITEM_PORT_MODE = 4'hA,
    TPC_ITEM_TP_MODE   = 4'hB
  } tpc_item_t;

  typedef enum logic [1:0] {
    TPC_PORT_MONITORED     = 2'h0,
    TPC_PORT_AUTO          = 2'h1,
    TPC_PORT_NOT_MONITORED = 2'h2
  } tpc_port_mode_t;

  typedef enum logic {
    TPC_TP_MONITORED     = 1'b0,
    TPC_TP_NOT_MONITORED = 1'b1
  } tpc_tp_mode_t;

  typedef enum logic {
    TPC_CONN_UNPROTECTED = 1'b0,
    TPC_CONN_PROT_1P1    = 1'b1
  } tpc_conn_kind_t;

  typedef enum logic {
    TPC_CONN_UNIDIR = 1'b0,
    TPC_CONN_BIDIR  = 1'b1
  } tpc_conn_dir_t;

  // split bit 1: group broken into lower groups or units
  typedef struct packed {
    logic                         aug16_split;
    logic [`TPC_AUG4_NUM-1:0]     aug4_split;
  } tpc_aug_t;

  typedef struct packed {
    logic [`TPC_TUG3_NUM-1:0]     tug3_split;
    logic [`TPC_TUG2_NUM-1:0]     tug2_split;
  } tpc_tug_t;

  typedef struct packed {
    logic                                        defined;
    tpc_conn_dir_t                               dir;
    tpc_conn_kind_t                              kind;
    logic [`TPC_CP_NUM-1:0][`TPC_CP_ID_W-1:0]   cp_ids;
  } tpc_conn_t;

  typedef struct packed {
    logic [`TPC_AF_MAX-1:0]      active;
    logic [`TPC_LABEL_W-1:0]     label;
    logic                        label_valid;
    tpc_aug_t                    aug_work;
    tpc_aug_t                    aug_prot;
    tpc_aug_t                    aug_rx;
    tpc_tug_t                    tug;
    tpc_conn_t                   conn;
    logic [`TPC_AP_ID_W-1:0]     ap_work_id;
    logic [`TPC_AP_ID_W-1:0]     ap_prot_id;
    logic                        deg_ses;
    logic [`TPC_DEG_THR_W-1:0]   deg_thr;
    logic [`TPC_DEG_M_W-1:0]     deg_m;
    tpc_port_mode_t              port_mode;
    tpc_tp_mode_t                tp_mode;
    logic                        accept;
    logic                        reject;
  } tpc_state_t;

endpackage

// [tb/tpc_bank_chk.sv]
// assertions on the ports of the transport provisioning register bank
// assumes one clock, synchronous active-high reset, default support set
`timescale 1ns/100ps
`default_nettype none
`include "tpc_params.svh"
module tpc_bank_chk
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic           core_clk,
  input wire logic           sys_rst,
  // command and label
  input wire logic           cmd_valid,
  input wire logic           cmd_accept,
  input wire logic           cmd_reject,
  input wire logic           label_req,
  input wire logic [7:0]     rx_payload_label,
  input wire logic [7:0]     accepted_payload_label,
  input wire logic           label_valid,
  // structures
  input wire logic           ring_pass_through,
  input wire logic           rx_aug_valid,
  input wire tpc_aug_t       rx_aug_detect,
  input wire tpc_aug_t       rx_aug_report,
  input wire tpc_aug_t       aug_work_cfg,
  input wire tpc_aug_t       aug_prot_cfg,
  // settings
  input wire tpc_conn_t      conn_cfg,
  input wire logic           degraded_use_ses,
  input wire logic [3:0]     degraded_period_count,
  input wire tpc_port_mode_t port_monitor_setting,
  input wire tpc_tp_mode_t   termination_monitor_setting
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_lbl_ans;
    label_valid && accepted_payload_label == $past(rx_payload_label);
  endsequence
  sequence s_calm;
    !ring_pass_through [*2];
  endsequence

  property p_ans;
    cmd_valid |=> cmd_accept != cmd_reject;
  endproperty
  property p_quiet;
    !cmd_valid |=> !cmd_accept && !cmd_reject;
  endproperty
  property p_rej_keep;
    cmd_reject |-> $stable(aug_work_cfg) && $stable(degraded_period_count)
      && $stable(port_monitor_setting);
  endproperty
  property p_lbl;
    label_req |=> s_lbl_ans;
  endproperty
  property p_rx;
    rx_aug_valid |=> rx_aug_report == $past(rx_aug_detect);
  endproperty
  property p_follow;
    ring_pass_through && rx_aug_valid |=> aug_prot_cfg == $past(rx_aug_detect);
  endproperty
  property p_prot_eq;
    s_calm |-> aug_prot_cfg == aug_work_cfg;
  endproperty
  property p_range;
    1'b1 |-> degraded_period_count inside {[4'h2:4'hA]};
  endproperty
  property p_rst;
    $fell(sys_rst) |-> degraded_period_count == 4'h7 && degraded_use_ses
      && port_monitor_setting == TPC_PORT_AUTO && !conn_cfg.defined
      && termination_monitor_setting == TPC_TP_NOT_MONITORED;
  endproperty

  a_ans: assert property (p_ans) else $error("no single answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_rej_keep: assert property (p_rej_keep) else $error("refused write");
  a_lbl: assert property (p_lbl) else $error("label not returned");
  a_rx: assert property (p_rx) else $error("rx structure report");
  a_follow: assert property (p_follow) else $error("prot no follow");
  a_prot_eq: assert property (p_prot_eq) else $error("prot vs work");
  a_range: assert property (p_range) else $error("period range");
  a_rst: assert property (p_rst) else $error("reset values");
endmodule

bind tpc_config_bank tpc_bank_chk i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .label_req(label_req),
  .rx_payload_label(rx_payload_label), .label_valid(label_valid),
  .accepted_payload_label(accepted_payload_label),
  .ring_pass_through(ring_pass_through), .rx_aug_valid(rx_aug_valid),
  .rx_aug_detect(rx_aug_detect), .rx_aug_report(rx_aug_report),
  .aug_work_cfg(aug_work_cfg), .aug_prot_cfg(aug_prot_cfg),
  .conn_cfg(conn_cfg), .degraded_use_ses(degraded_use_ses),
  .degraded_period_count(degraded_period_count),
  .port_monitor_setting(port_monitor_setting),
  .termination_monitor_setting(termination_monitor_setting));
`default_nettype wire

// [tb/tpc_mgmt_model.sv]
// management side model issuing provisioning commands
// assumes the bank answers one cycle after the strobe edge
`timescale 1ns/100ps
`default_nettype none
module tpc_mgmt_model
  import tpc_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // command out, answer in
  output var  logic        cmd_valid,
  output var  tpc_item_t   cmd_item,
  output var  logic [4:0]  cmd_index,
  output var  logic [31:0] cmd_data,
  input  wire logic        cmd_accept,
  input  wire logic        cmd_reject
);
  initial begin
    cmd_valid = 1'b0;
    cmd_item  = TPC_ITEM_ACTIVE;
    cmd_index = 5'h00;
    cmd_data  = 32'h0;
  end

  // whole command on one strobe; data inverted once released
  task automatic issue(input tpc_item_t it, input logic [4:0] ix,
                       input logic [31:0] dt, output logic [1:0] ans);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_item  = it;
    cmd_index = ix;
    cmd_data  = dt;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_data  = ~dt;
    ans = {cmd_accept, cmd_reject};
  endtask
endmodule
`default_nettype wire

// [tb/tb_transport_provisioning_config.sv]
// self-checking bench of the transport provisioning register bank
// assumes the checker bind and the management model are compiled
`timescale 1ns/100ps
`default_nettype none
module tb_transport_provisioning_config;
  import tpc_pkg::*;
  logic core_clk, sys_rst, cmd_valid, cmd_accept, cmd_reject, label_req;
  logic label_valid, ring_pass_through, rx_aug_valid, degraded_use_ses;
  tpc_item_t cmd_item;
  logic [4:0] cmd_index;
  logic [31:0] cmd_data;
  logic [7:0] rx_payload_label, accepted_payload_label, client_activate;
  tpc_aug_t rx_aug_detect, rx_aug_report, aug_work_cfg, aug_prot_cfg;
  tpc_tug_t tug_cfg;
  tpc_conn_t conn_cfg;
  logic [11:0] ap_working_id, ap_normal_id, ap_protection_id, ap_extra_id;
  logic [15:0] degraded_block_threshold;
  logic [3:0] degraded_period_count, m_exp;
  tpc_port_mode_t port_monitor_setting;
  tpc_tp_mode_t termination_monitor_setting;
  logic [3:0] m_tab [4] = '{4'h1, 4'h2, 4'hA, 4'hB};
  logic [7:0] fx_act;
  logic fx_rej;
  int fails, cmp_count;

  tpc_config_bank #(.NUM_AF(4), .SINGLE_CLIENT(1'b0), .FIXED_ACTIVE(1'b0))
  i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_item(cmd_item), .cmd_index(cmd_index), .cmd_data(cmd_data),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .label_req(label_req),
    .rx_payload_label(rx_payload_label), .label_valid(label_valid),
    .accepted_payload_label(accepted_payload_label),
    .ring_pass_through(ring_pass_through), .rx_aug_valid(rx_aug_valid),
    .rx_aug_detect(rx_aug_detect), .rx_aug_report(rx_aug_report),
    .client_activate(client_activate), .aug_work_cfg(aug_work_cfg),
    .aug_prot_cfg(aug_prot_cfg), .tug_cfg(tug_cfg), .conn_cfg(conn_cfg),
    .ap_working_id(ap_working_id), .ap_normal_id(ap_normal_id),
    .ap_protection_id(ap_protection_id), .ap_extra_id(ap_extra_id),
    .degraded_use_ses(degraded_use_ses),
    .degraded_block_threshold(degraded_block_threshold),
    .degraded_period_count(degraded_period_count),
    .port_monitor_setting(port_monitor_setting),
    .termination_monitor_setting(termination_monitor_setting));

  tpc_mgmt_model i_mgr (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_item(cmd_item), .cmd_index(cmd_index), .cmd_data(cmd_data),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject));

  // fixed single client, no AU-4-4c, no TU2
  tpc_config_bank #(.SUP_AU4_4C(1'b0), .SUP_TU2(1'b0), .AUG_DEFAULT(5'h0F))
  i_dut_fix (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_item(cmd_item), .cmd_index(cmd_index), .cmd_data(cmd_data),
    .cmd_accept(), .cmd_reject(fx_rej), .label_req(label_req),
    .rx_payload_label(rx_payload_label), .label_valid(),
    .accepted_payload_label(), .ring_pass_through(ring_pass_through),
    .rx_aug_valid(rx_aug_valid), .rx_aug_detect(rx_aug_detect),
    .rx_aug_report(), .client_activate(fx_act), .aug_work_cfg(),
    .aug_prot_cfg(), .tug_cfg(), .conn_cfg(), .ap_working_id(),
    .ap_normal_id(), .ap_protection_id(), .ap_extra_id(),
    .degraded_use_ses(), .degraded_block_threshold(),
    .degraded_period_count(), .port_monitor_setting(),
    .termination_monitor_setting());

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input tpc_item_t it, input logic [4:0] ix,
                    input logic [31:0] dt, input logic ok);
    logic [1:0] ans;
    i_mgr.issue(it, ix, dt, ans);
    chk("answer", ans, ok ? 2'b10 : 2'b01);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    label_req = 1'b0;
    rx_payload_label = 8'h00;
    ring_pass_through = 1'b0;
    rx_aug_valid = 1'b0;
    rx_aug_detect = 5'h00;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("period", degraded_period_count, 4'h7);
    chk("ses", degraded_use_ses, 1'b1);
    chk("active", client_activate, 8'h00);
    chk("fixed active", fx_act, 8'h01);
    chk("conn", conn_cfg, 27'h0);
    wr(TPC_ITEM_ACTIVE, 5'h02, 32'h1, 1'b1);
    chk("fixed refuse", fx_rej, 1'b1);
    wr(TPC_ITEM_ACTIVE, 5'h04, 32'h1, 1'b0);
    chk("active", client_activate, 8'h04);
    chk("fixed active", fx_act, 8'h01);
    // split to four groups, then last group into single units
    wr(TPC_ITEM_AUG16, 5'h00, 32'h1, 1'b1);
    wr(TPC_ITEM_AUG4, 5'h03, 32'h1, 1'b1);
    chk("no aug4 level", fx_rej, 1'b1);
    wr(TPC_ITEM_AUG4, 5'h04, 32'h1, 1'b0);
    chk("aug", aug_work_cfg, 5'h18);
    chk("aug prot", aug_prot_cfg, 5'h18);
    wr(TPC_ITEM_TUG3, 5'h01, 32'h0, 1'b1);
    chk("tug3 direct", fx_rej, 1'b0);
    wr(TPC_ITEM_TUG2, 5'h14, 32'h0, 1'b1);
    chk("no tug2 level", fx_rej, 1'b1);
    wr(TPC_ITEM_TUG3, 5'h03, 32'h0, 1'b0);
    wr(TPC_ITEM_TUG2, 5'h15, 32'h0, 1'b0);
    chk("tug", tug_cfg, 24'hAFFFFF);
    for (int k = 0; k < 4; k++) begin
      wr(TPC_ITEM_CONN, 5'h00, {6'h00, 2'(k), 24'hABC123}, 1'b1);
      chk("conn", conn_cfg, {5'h00, 1'b1, 2'(k), 24'hABC123});
    end
    wr(TPC_ITEM_AP_WORK, 5'h00, 32'h5A5, 1'b1);
    wr(TPC_ITEM_AP_PROT, 5'h00, 32'h3C3, 1'b1);
    chk("normal", {ap_working_id, ap_normal_id}, 24'h5A55A5);
    chk("extra", {ap_protection_id, ap_extra_id}, 24'h3C33C3);
    wr(TPC_ITEM_DEG_THR, 5'h00, 32'h1234, 1'b1);
    chk("thr", {degraded_use_ses, degraded_block_threshold}, 17'h1234);
    m_exp = 4'h7;
    for (int k = 0; k < 4; k++) begin
      wr(TPC_ITEM_DEG_M, 5'h00, 32'(m_tab[k]),
         m_tab[k] inside {[2:10]});
      if (m_tab[k] inside {[2:10]}) m_exp = m_tab[k];
      chk("period", degraded_period_count, m_exp);
    end
    for (int k = 3; k >= 0; k--) begin
      wr(TPC_ITEM_PORT_MODE, 5'h00, 32'(k), k < 3);
      chk("port", port_monitor_setting, (k == 3) ? 2'h1 : 2'(k));
    end
    wr(TPC_ITEM_TP_MODE, 5'h00, 32'h0, 1'b1);
    chk("tp", termination_monitor_setting, TPC_TP_MONITORED);
    // back-to-back label requests
    @(negedge core_clk);
    label_req = 1'b1;
    rx_payload_label = 8'h5C;
    @(negedge core_clk);
    rx_payload_label = 8'hA3;
    chk("label", {label_valid, accepted_payload_label}, 9'h15C);
    @(negedge core_clk);
    label_req = 1'b0;
    rx_payload_label = 8'h5C;
    chk("label", {label_valid, accepted_payload_label}, 9'h1A3);
    @(negedge core_clk);
    chk("label", {label_valid, accepted_payload_label}, 9'h0A3);
    ring_pass_through = 1'b1;
    rx_aug_valid = 1'b1;
    rx_aug_detect = 5'h15;
    @(negedge core_clk);
    rx_aug_valid = 1'b0;
    rx_aug_detect = 5'h0A;
    chk("report", rx_aug_report, 5'h15);
    chk("prot", aug_prot_cfg, 5'h15);
    wr(TPC_ITEM_AUG16, 5'h00, 32'h0, 1'b1);
    chk("prot", aug_prot_cfg, 5'h15);
    chk("aug", aug_work_cfg, 5'h08);
    ring_pass_through = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("prot", aug_prot_cfg, 5'h08);
    wrap_up();
  end
endmodule
`default_nettype wire
